// >>> logic/rsq_sequencer.sv
// Enable/delay sequencer for two step-down converters and two linear regulators
// Functional notes
// - Linreg B control bit 2 engages discharge while off; resets to one.
// - Linreg B control bit 1: zero software only, one software and pin.
// - Linreg B control bit 0 is the software enable.
// - Linreg B control bits 7:3 reserved, read-write, reset zero.
// - Linreg A voltage code bits 4:0, 0.8 V plus 100 mV per code.
// - Linreg B voltage code uses the same mapping; above 0x19 reserved.
// - Stepdown A starts after bits 3:0 half-millisecond steps from pin rise.
// - Stepdown A stops after bits 7:4 half-millisecond steps from pin fall.
// - Global rise select doubles every startup step to 1 ms.
// - Global fall select doubles every shutdown step to 1 ms.
// - Stepdown B startup delay from bits 3:0 after pin rise.
// - Stepdown B shutdown delay from bits 7:4 after pin fall.
// - Linreg A startup delay from bits 3:0 after pin rise.
// - Linreg A shutdown delay from bits 7:4 after pin fall.
// - Linreg B startup and shutdown delays from bits 3:0 and 7:4.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module rsq_sequencer #(
   parameter int STEP_CYC = rsq_pkg::STEP_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rsq_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External enable pin
   input wire logic enable_pin,
   // Rail controls
   output rsq_pkg::rsq_rails_t rails,
   output logic [rsq_pkg::VOLT_W-1:0] linreg_a_volt_code,
   output logic [rsq_pkg::VOLT_W-1:0] linreg_b_volt_code
);
   import rsq_pkg::*;

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [7:0] linreg_b_control;
   logic [7:0] linreg_a_control;
   logic [7:0] linreg_a_voltage;
   logic [7:0] linreg_b_voltage;
   logic [7:0] wait_reg [NUM_RAILS];
   logic [7:0] seq_config;

   logic wr_en;
   logic [ADDR_W-1:0] word_addr;
   logic hit;
   logic [7:0] rd_byte;
   logic [7:0] status_byte;

   // Byte address is four times the index
   function automatic logic [ADDR_W-1:0] idx_addr(input logic [7:0] idx);
      return ADDR_W'({idx, 2'b00});
   endfunction : idx_addr

   assign wr_en = psel && penable && pwrite && pstrb[0];
   assign word_addr = paddr;
   assign pready = 1'b1;

   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      unique case (word_addr)
         idx_addr(IDX_LINREG_B_CONTROL): rd_byte = linreg_b_control;
         idx_addr(IDX_LINREG_A_CONTROL): rd_byte = linreg_a_control;
         idx_addr(IDX_LINREG_A_VOLTAGE): rd_byte = linreg_a_voltage;
         idx_addr(IDX_LINREG_B_VOLTAGE): rd_byte = linreg_b_voltage;
         idx_addr(IDX_STEPDOWN_A_DELAY): rd_byte = wait_reg[0];
         idx_addr(IDX_STEPDOWN_B_DELAY): rd_byte = wait_reg[1];
         idx_addr(IDX_LINREG_A_DELAY): rd_byte = wait_reg[2];
         idx_addr(IDX_LINREG_B_DELAY): rd_byte = wait_reg[3];
         idx_addr(IDX_SEQ_CONFIG): rd_byte = seq_config;
         idx_addr(IDX_SEQ_STATUS): rd_byte = status_byte;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= {24'h00_0000, rd_byte};
            pslverr <= !hit;
         end
      end
   end

   // Control registers; reserved bits kept as plain storage
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         linreg_b_control <= RST_CONTROL;
         linreg_a_control <= RST_CONTROL;
      end else if (wr_en) begin
         if (word_addr == idx_addr(IDX_LINREG_B_CONTROL)) begin
            linreg_b_control <= pwdata[7:0];
         end
         if (word_addr == idx_addr(IDX_LINREG_A_CONTROL)) begin
            linreg_a_control <= pwdata[7:0];
         end
      end
   end

   // Voltage codes pass unfiltered; reserved codes are software's to avoid
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         linreg_a_voltage <= RST_ZERO;
         linreg_b_voltage <= RST_ZERO;
      end else if (wr_en) begin
         if (word_addr == idx_addr(IDX_LINREG_A_VOLTAGE)) begin
            linreg_a_voltage <= pwdata[7:0];
         end
         if (word_addr == idx_addr(IDX_LINREG_B_VOLTAGE)) begin
            linreg_b_voltage <= pwdata[7:0];
         end
      end
   end

   assign linreg_a_volt_code = linreg_a_voltage[VOLT_W-1:0];
   assign linreg_b_volt_code = linreg_b_voltage[VOLT_W-1:0];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_RAILS; i++) begin
            wait_reg[i] <= RST_ZERO;
         end
         seq_config <= RST_ZERO;
      end else if (wr_en) begin
         if (word_addr == idx_addr(IDX_STEPDOWN_A_DELAY)) wait_reg[0] <= pwdata[7:0];
         if (word_addr == idx_addr(IDX_STEPDOWN_B_DELAY)) wait_reg[1] <= pwdata[7:0];
         if (word_addr == idx_addr(IDX_LINREG_A_DELAY)) wait_reg[2] <= pwdata[7:0];
         if (word_addr == idx_addr(IDX_LINREG_B_DELAY)) wait_reg[3] <= pwdata[7:0];
         if (word_addr == idx_addr(IDX_SEQ_CONFIG)) seq_config <= {6'h00, pwdata[1:0]};
      end
   end

   // ----------------------------------------
   // Enable pin sync and timebase
   // ----------------------------------------
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;
   logic pin_rise;
   logic pin_fall;
   logic [23:0] base_cnt;
   logic tick;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= enable_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign pin_rise = pin_sync && !pin_prev;
   assign pin_fall = !pin_sync && pin_prev;

   // Free-running base; a delay may end up to one step early, never a step late
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         base_cnt <= 24'h00_0000;
      end else if (base_cnt == 24'(STEP_CYC - 1)) begin
         base_cnt <= 24'h00_0000;
      end else begin
         base_cnt <= base_cnt + 24'h00_0001;
      end
   end

   assign tick = (base_cnt == 24'(STEP_CYC - 1));

   // ----------------------------------------
   // Per-rail sequencing
   // ----------------------------------------
   logic [NUM_RAILS-1:0] sw_on;
   logic [NUM_RAILS-1:0] gated;
   logic [NUM_RAILS-1:0] discharge_sel;
   rsq_state_t state [NUM_RAILS];
   logic [4:0] steps [NUM_RAILS];

   // Steps to wait: code, doubled when the matching select bit is one
   function automatic logic [4:0] wait_steps(input logic [3:0] code, input logic dbl);
      return dbl ? {code, 1'b0} : {1'b0, code};
   endfunction : wait_steps

   // Other rails take their enable bits from the extra control register (all share it)
   always_comb begin
      for (int i = 0; i < NUM_RAILS; i++) begin
         sw_on[i] = linreg_a_control[CTL_SW_ON];
         gated[i] = linreg_a_control[CTL_PIN_GATING];
         discharge_sel[i] = linreg_a_control[CTL_DISCHARGE];
      end
      sw_on[RAIL_LINREG_B] = linreg_b_control[CTL_SW_ON];
      gated[RAIL_LINREG_B] = linreg_b_control[CTL_PIN_GATING];
      discharge_sel[RAIL_LINREG_B] = linreg_b_control[CTL_DISCHARGE];
   end

   for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            state[g] <= RSQ_OFF;
            steps[g] <= 5'h00;
         end else if (!gated[g]) begin
            state[g] <= sw_on[g] ? RSQ_ON : RSQ_OFF;
            steps[g] <= 5'h00;
         end else if (pin_rise) begin
            state[g] <= RSQ_RISING;
            steps[g] <= wait_steps(wait_reg[g][RISE_LSB +: WAIT_W],
                                   seq_config[CFG_RISE_DOUBLE]);
         end else if (pin_fall) begin
            state[g] <= RSQ_FALLING;
            steps[g] <= wait_steps(wait_reg[g][FALL_LSB +: WAIT_W],
                                   seq_config[CFG_FALL_DOUBLE]);
         end else begin
            unique case (state[g])
               RSQ_RISING: begin
                  if (steps[g] == 5'h00) begin
                     state[g] <= RSQ_ON;
                  end else if (tick) begin
                     steps[g] <= steps[g] - 5'h01;
                  end
               end
               RSQ_FALLING: begin
                  if (steps[g] == 5'h00) begin
                     state[g] <= RSQ_OFF;
                  end else if (tick) begin
                     steps[g] <= steps[g] - 5'h01;
                  end
               end
               RSQ_OFF: if (pin_sync) state[g] <= RSQ_ON;
               RSQ_ON: if (!pin_sync) state[g] <= RSQ_OFF;
            endcase
         end
      end
   end

   // Rail on needs the sequencer state (pin-driven only when gated) and the software bit together
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rails <= '0;
      end else begin
         for (int i = 0; i < NUM_RAILS; i++) begin
            rails.enable[i] <= sw_on[i] && (state[i] == RSQ_ON || state[i] == RSQ_FALLING);
            rails.discharge[i] <= discharge_sel[i] &&
                                  !(sw_on[i] && (state[i] == RSQ_ON || state[i] == RSQ_FALLING));
         end
      end
   end

   always_comb begin
      status_byte = {4'h0, rails.enable};
   end
endmodule : rsq_sequencer

// >>> pkg/rsq_pkg.sv
// Package: register map, field layout and timing constants of the enable sequencer
package rsq_pkg;
   // ----------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------
   // Printed offsets are not all multiples of four, so they are indices
   localparam logic [7:0] IDX_LINREG_B_CONTROL = 8'h09;
   localparam logic [7:0] IDX_LINREG_A_VOLTAGE = 8'h0a;
   localparam logic [7:0] IDX_LINREG_B_VOLTAGE = 8'h0b;
   localparam logic [7:0] IDX_STEPDOWN_A_DELAY = 8'h0c;
   localparam logic [7:0] IDX_STEPDOWN_B_DELAY = 8'h0d;
   localparam logic [7:0] IDX_LINREG_A_DELAY = 8'h0e;
   localparam logic [7:0] IDX_LINREG_B_DELAY = 8'h0f;
   localparam logic [7:0] IDX_SEQ_CONFIG = 8'h20;
   localparam logic [7:0] IDX_SEQ_STATUS = 8'h21;
   localparam logic [7:0] IDX_LINREG_A_CONTROL = 8'h22;
   localparam int ADDR_W = 12;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTL_SW_ON = 0;
   localparam int CTL_PIN_GATING = 1;
   localparam int CTL_DISCHARGE = 2;
   localparam int CFG_RISE_DOUBLE = 0;
   localparam int CFG_FALL_DOUBLE = 1;
   localparam int RISE_LSB = 0;
   localparam int FALL_LSB = 4;
   localparam int WAIT_W = 4;
   localparam int VOLT_W = 5;
   localparam int NUM_RAILS = 4;
   localparam int RAIL_LINREG_B = 3;

   // ----------------------------------------
   // Reset values and voltage code limit
   // ----------------------------------------
   localparam logic [7:0] RST_CONTROL = 8'h04;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [4:0] VOLT_MAX_CODE = 5'h19;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int STEP_US = 500;
   localparam int STEP_CYCLES = (CLK_HZ / 1000) * STEP_US / 1000;

   // Per-rail sequencing state
   typedef enum logic [1:0] {RSQ_OFF, RSQ_RISING, RSQ_ON, RSQ_FALLING} rsq_state_t;

   // Rail outputs travelling together
   typedef struct packed {
      logic [NUM_RAILS-1:0] enable;
      logic [NUM_RAILS-1:0] discharge;
   } rsq_rails_t;
endpackage : rsq_pkg

// >>> dv/rsq_sequencer_asserts.sv
// Checker: port-level properties of the enable sequencer
`timescale 1ns/1ps
module rsq_chk #(
   parameter int STEP_CYC = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rsq_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin and rails
   input wire logic enable_pin,
   input wire rsq_pkg::rsq_rails_t rails,
   input wire logic [rsq_pkg::VOLT_W-1:0] linreg_a_volt_code,
   input wire logic [rsq_pkg::VOLT_W-1:0] linreg_b_volt_code
);
   import rsq_pkg::*;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   wire acc = psel && penable && pwrite && pstrb[0];
   property p_disch_excl;
      (rails.discharge & rails.enable) == 4'h0;
   endproperty
   a_disch_excl: assert property (p_disch_excl) else $error("discharge while on");
   property p_rst_disch;
      $fell(sys_rst) |-> ##[1:2] rails.discharge == 4'hf;
   endproperty
   a_rst_disch: assert property (p_rst_disch) else $error("discharge after reset");
   property p_volt_a;
      !$stable(linreg_a_volt_code) |-> $past(acc && paddr == 12'h28);
   endproperty
   a_volt_a: assert property (p_volt_a) else $error("volt a moved");
   property p_volt_b;
      !$stable(linreg_b_volt_code) |-> $past(acc && paddr == 12'h2c);
   endproperty
   a_volt_b: assert property (p_volt_b) else $error("volt b moved");
   property p_sw_on;
      acc && paddr == 12'h24 && pwdata[1:0] == 2'b01 |-> ##[1:4] rails.enable[3];
   endproperty
   a_sw_on: assert property (p_sw_on) else $error("sw enable ignored");
   property p_sw_off;
      acc && paddr == 12'h24 && !pwdata[0] |-> ##[1:4] !rails.enable[3];
   endproperty
   a_sw_off: assert property (p_sw_off) else $error("sw disable ignored");
   // Pin held low long enough that no fall edge is left in the synchroniser
   property p_gate;
      acc && paddr == 12'h24 && pwdata[1:0] == 2'b11 && !enable_pin && !$past(enable_pin, 4)
         |-> ##4 !rails.enable[3] [*4];
   endproperty
   a_gate: assert property (p_gate) else $error("gated rail on with pin low");
   property p_pin_sync;
      $rose(enable_pin) && !psel |=> $stable(rails.enable) [*2];
   endproperty
   a_pin_sync: assert property (p_pin_sync) else $error("pin edge not synced");
   c_gate: cover property (acc && paddr == 12'h24 && pwdata[1:0] == 2'b11);
   c_rise: cover property ($rose(rails.enable[0]));
   c_err: cover property (pslverr);
endmodule : rsq_chk

// >>> dv/rsq_host.sv
// Host model: APB master and enable pin driver
`timescale 1ns/1ps
module rsq_host (
   // Clock
   input wire logic core_clk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [rsq_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic pready,
   // Enable pin
   output logic enable_pin
);
   import rsq_pkg::*;
   // ----------------------------------------
   // Bus and pin tasks
   // ----------------------------------------
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h0;
      enable_pin = 1'b0;
   end
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= 4'hf;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines must not look valid
      paddr <= ~a;
      pwdata <= ~pwdata;
   endtask : xfer
   task automatic pin(input logic v);
      @(posedge core_clk);
      enable_pin <= v;
   endtask : pin
endmodule : rsq_host

// >>> dv/tb.sv
// Testbench: registers, voltage codes and enable sequencing
`timescale 1ns/1ps
module tb;
   import rsq_pkg::*;
   // ----------------------------------------
   // Signals, instances, checking
   // ----------------------------------------
   localparam int STEP = 8;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, enable_pin;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [VOLT_W-1:0] linreg_a_volt_code, linreg_b_volt_code;
   rsq_rails_t rails;
   logic [32:0] exp_q[$];
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   always #12.5 core_clk = ~core_clk;
   rsq_sequencer #(.STEP_CYC(STEP)) i_rsq_sequencer (.core_clk, .sys_rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .enable_pin, .rails,
      .linreg_a_volt_code, .linreg_b_volt_code);
   rsq_host i_rsq_host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .pready, .enable_pin);
   task automatic check(string name, logic [32:0] seen, logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic summarize();
      if (n_fail == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         summarize();
      end
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         check("read", {pslverr, prdata}, exp_q.pop_front());
      end
   end
   task automatic wr(logic [7:0] idx, logic [7:0] d);
      i_rsq_host.xfer(1'b1, {2'b00, idx, 2'b00}, d);
   endtask : wr
   task automatic rd(logic [7:0] idx, logic [32:0] e);
      exp_q.push_back(e);
      i_rsq_host.xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00);
   endtask : rd
   task automatic settle();
      repeat (4) @(negedge core_clk);
   endtask : settle
   // Rise uses code c, fall uses 15 - c, so the two fields differ
   task automatic pin_run(logic lvl, logic [3:0] c[4], int u);
      int t[4] = '{default: -1};
      int n;
      logic ok;
      i_rsq_host.pin(lvl);
      for (int k = 0; k < 300; k++) begin
         @(negedge core_clk);
         foreach (t[i]) begin
            if (t[i] < 0 && rails.enable[i] === lvl) begin
               t[i] = k;
            end
         end
      end
      foreach (t[i]) begin
         n = u * (lvl ? c[i] : 4'hf - c[i]);
         ok = t[i] >= (n - 1) * STEP && t[i] <= n * STEP + 10;
         check("delay", ok, 1);
      end
   endtask : pin_run
   initial begin
      logic [7:0] d;
      logic [3:0] c[4];
      void'($urandom(32'h01e2780a));
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(IDX_LINREG_B_CONTROL, 33'h4);
      check("discharge", rails.discharge, 4'hf);
      rd(8'h10, 33'h1_0000_0000);
      for (int i = 9; i <= 15; i++) begin
         d = 8'($urandom);
         if (i == 10 || i == 11) begin
            d[4:0] = 5'(d[4:0] % 26);
         end
         wr(8'(i), d);
         rd(8'(i), {25'h0, d});
      end
      wr(IDX_LINREG_A_VOLTAGE, 8'h19);
      wr(IDX_LINREG_B_VOLTAGE, 8'he0);
      settle();
      check("volt_a", linreg_a_volt_code, 5'h19);
      check("volt_b", linreg_b_volt_code, 5'h00);
      wr(IDX_LINREG_A_CONTROL, 8'h07);
      wr(IDX_LINREG_B_CONTROL, 8'h07);
      for (int u = 1; u <= 2; u++) begin
         c = '{4'h0, 4'($urandom), 4'($urandom), 4'hf};
         wr(IDX_SEQ_CONFIG, u == 2 ? 8'h03 : 8'h00);
         foreach (c[i]) begin
            wr(8'(IDX_STEPDOWN_A_DELAY + i), {4'hf - c[i], c[i]});
         end
         pin_run(1'b1, c, u);
         check("disch_on", rails.discharge, 4'h0);
         rd(IDX_SEQ_STATUS, 33'h0_0000_000f);
         rd(IDX_SEQ_CONFIG, u == 2 ? 33'h0_0000_0003 : 33'h0_0000_0000);
         pin_run(1'b0, c, u);
      end
      wr(IDX_LINREG_B_CONTROL, 8'h01);
      settle();
      check("sw_only", rails.enable[3], 1'b1);
      wr(IDX_LINREG_B_CONTROL, 8'h03);
      settle();
      check("gated_low", rails.enable[3], 1'b0);
      wr(IDX_LINREG_B_CONTROL, 8'h00);
      settle();
      check("no_disch", rails.discharge[3], 1'b0);
      summarize();
   end
endmodule : tb
bind rsq_sequencer rsq_chk #(.STEP_CYC(STEP_CYC)) i_rsq_chk (.core_clk, .sys_rst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .enable_pin,
   .rails, .linreg_a_volt_code, .linreg_b_volt_code);
